// file: logic/tsr_pkg.sv
// Shared constants, types and tables for the target/slew ramp engine
package tsr_pkg;

  // Register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CORE_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_TGT_CFG   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_TGT_DATA  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_SLEW_IDX  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_SLEW_VAL  = 8'h10;

  // Audio core control bit positions
  localparam int BIT_LOAD_GO   = 2;
  localparam int BIT_MUTE      = 3;
  localparam int BIT_CLR_HI    = 6;
  localparam int BIT_MEMCLR    = 7;
  localparam int BIT_CLR_N     = 9;
  localparam int BIT_RAMP_DN   = 12;
  localparam int BIT_RAMP_DONE = 13;

  // Staging configuration field positions
  localparam int CFG_UPPER_LSB = 0;
  localparam int CFG_IDX_LSB   = 8;

  // Memory geometry
  localparam int SLOTS = 64;
  localparam int IDX_W = 6;
  localparam int VAL_W = 28;
  localparam int CNT_W = 14;
  localparam logic [IDX_W-1:0] IDX_LAST = 6'h3f;

  // Timing
  localparam longint CLK_HZ         = 40_000_000;
  localparam longint MEMCLR_TIME_US = 100;
  localparam int     MEMCLR_CYCLES  = int'((CLK_HZ / 1000 * MEMCLR_TIME_US + 999) / 1000);
  localparam int     MCLR_W         = 13;

  // Curve type encoding
  typedef enum logic [1:0] {
    CURVE_LIN = 2'h0,
    CURVE_CDB = 2'h1,
    CURVE_RC  = 2'h2,
    CURVE_CT  = 2'h3
  } tsr_curve_type;

  // One target entry; for constant time tconst holds {update, step code}
  typedef struct packed {
    tsr_curve_type    curve;
    logic [3:0]       tconst;
    logic [VAL_W-1:0] data;
  } tsr_target_type;

  // Software visible control bits
  typedef struct packed {
    logic load_go;
    logic mute;
    logic clr_hi;
    logic memclr;
    logic clr_n;
    logic ramp_dn;
  } tsr_ctrl_type;

  // Engine sequencer states
  typedef enum logic [1:0] {
    ST_INIT = 2'h0,
    ST_IDLE = 2'h1,
    ST_SCAN = 2'h3
  } tsr_state_type;

  // Reset values
  localparam tsr_ctrl_type     CTRL_RESET   = '0;
  localparam logic [VAL_W-1:0] UNITY        = 28'h0800000;
  localparam logic [3:0]       RESET_TCONST = 4'h5;
  localparam tsr_target_type   TGT_RESET    = '{curve: CURVE_LIN, tconst: RESET_TCONST, data: UNITY};

  // Ramp shaping constants
  localparam logic [3:0]       EXP_SHIFT_MIN = 4'h5;
  localparam logic [3:0]       CT_BASE_SHIFT = 4'h6;
  localparam logic [2:0]       CT_TOP_CODE   = 3'h7;
  localparam logic [CNT_W-1:0] CT_TOP_COUNT  = 14'd8196;
  localparam logic [8:0]       CT_FRAC_PAD   = 9'h000;

  // Linear step per time constant, 5.23 LSBs
  function automatic logic [15:0] lin_step(input logic [3:0] tc);
    unique case (tc)
      4'h0: lin_step = 16'h6531;
      4'h1: lin_step = 16'h5061;
      4'h2: lin_step = 16'h3fd9;
      4'h3: lin_step = 16'h32b7;
      4'h4: lin_step = 16'h2849;
      4'h5: lin_step = 16'h2000;
      4'h6: lin_step = 16'h196b;
      4'h7: lin_step = 16'h1431;
      4'h8: lin_step = 16'h100a;
      4'h9: lin_step = 16'h0cbd;
      4'ha: lin_step = 16'h0a1f;
      4'hb: lin_step = 16'h080a;
      4'hc: lin_step = 16'h0663;
      4'hd: lin_step = 16'h0512;
      4'he: lin_step = 16'h0407;
      4'hf: lin_step = 16'h0333;
    endcase
  endfunction

endpackage

// file: logic/tsr_ramp_engine.sv
// Target/slew ramp engine with audio core control bits
//
// Behaviour
// RULE1: Core clear output active while bit 9 low and bit 6 high.
// RULE2: Bit 7 starts a timed memory clear; hardware clears it after 100 us.
// RULE3: Host halts core, loads memories, runs memory clear, then releases core.
// RULE4: Bit 12 ramps volume down at each entry's pace; bit 13 reports completion.
// RULE5: Host ramps down before reload, clears bit 12 afterwards to ramp up.
// RULE6: Sixty-four slew values, each moving toward its paired target.
// RULE7: Every slew value takes one step per audio frame.
// RULE8: Target entry is 34 bits: six control bits over 28-bit 5.23 data.
// RULE9: Constant-time data holds 16-bit 2.14 target plus twelve reserved bits.
// RULE10: Mute forces effective targets to zero; release restores earlier targets.
// RULE11: Curve code 00 linear, 01 constant dB, 10 RC, 11 constant time.
// RULE12: Linear curve moves by one fixed step every frame.
// RULE13: Constant-dB step derives from current slew value by shifts and adds.
// RULE14: RC step derives from target minus slew, giving exponential approach.
// RULE15: Constant-time reaches target in fixed step count; mute ignores it.
// RULE16: Target word is curve, 4-bit time constant, then 28 data bits.
// RULE17: Update-step bit recalculates constant-time step, then clears itself.
// RULE18: Step count is 2^(n+6); code 111 gives 8196.
// RULE19: Host writes the twelve reserved constant-time bits as zero.
// RULE20: Reset gives linear, time constant 5, target and slew 1.0.
// RULE21: Linear step comes from time constant, normalised to 5.23.
// RULE22: Exponential curves span the documented time constant range via shifts.
// RULE23: Staged target transfer completes within one audio frame of request.
// RULE24: Steps stop exactly at target and hold there until a new target.
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps

module tsr_ramp_engine
  import tsr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              lrclk,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic [IDX_W-1:0]  dsp_idx,
  output logic      [VAL_W-1:0]  dsp_slew,
  output logic                   core_clear,
  output logic                   mem_clearing
);

  // Memories, filled by the init walk rather than by reset;
  // flop resets on 64 wide entries cost far more area
  // than a short walk, and no scan starts before it ends
  tsr_target_type          tgt_mem   [SLOTS];
  logic        [VAL_W-1:0] slew_mem  [SLOTS];
  logic signed [VAL_W-1:0] ct_step   [SLOTS];
  logic        [CNT_W-1:0] ct_left   [SLOTS];

  tsr_ctrl_type            ctrl;
  tsr_ctrl_type            next_ctrl;
  tsr_state_type           state;
  tsr_state_type           next_state;
  logic        [IDX_W-1:0] idx;
  logic        [13:0]      stage_cfg;
  logic        [VAL_W-1:0] stage_data;
  logic        [IDX_W-1:0] slew_sel;
  logic        [MCLR_W-1:0] mclr_cnt;
  logic                    nz_seen;
  logic                    ramp_done;
  logic                    lr_s1;
  logic                    lr_s2;
  logic                    lr_s3;

  // Bus decode
  // Reads have no side effects, so only writes decode
  wire logic wr_ctrl  = wr & (addr == OFF_CORE_CTRL);
  wire logic wr_cfg   = wr & (addr == OFF_TGT_CFG);
  wire logic wr_data  = wr & (addr == OFF_TGT_DATA);
  wire logic wr_sel   = wr & (addr == OFF_SLEW_IDX);

  // Frame tick on the synchronised LRCLK rising edge
  // Taken after the second flop: two cycles late,
  // but never metastable
  wire logic frame_tick = lr_s2 & ~lr_s3;

  // Pending staged target goes in at the first frame tick seen idle
  // One staging slot: one target per frame, and a
  // second write before the tick replaces the first
  wire logic load_take  = (state == ST_IDLE) & frame_tick & ctrl.load_go;
  wire logic memclr_set = wr_ctrl & wdata[BIT_MEMCLR];
  wire logic memclr_end = ctrl.memclr & (mclr_cnt == MCLR_W'(1));

  // RULE8: 34-bit target entry
  wire tsr_target_type   staged    = {stage_cfg[CFG_UPPER_LSB +: 6], stage_data};
  // RULE16: slot beside upper bits
  wire logic [IDX_W-1:0] stage_idx = stage_cfg[CFG_IDX_LSB +: IDX_W];

  // Current scanned entry
  // The scan walks in order, so one read port is enough
  wire tsr_target_type          cur      = tgt_mem[idx];
  wire logic        [VAL_W-1:0] cur_slew = slew_mem[idx];
  wire logic signed [VAL_W-1:0] cur_ctst = ct_step[idx];
  wire logic        [CNT_W-1:0] cur_left = ct_left[idx];

  // Only constant time needs a flag of its own
  // RULE11: curve decode
  wire logic is_ct = (cur.curve == CURVE_CT);

  // The low twelve reserved bits are never read
  // RULE9: 2.14 target widened to 5.23
  wire logic [VAL_W-1:0] ct_target = {{3{cur.data[27]}}, cur.data[27:12], CT_FRAC_PAD};

  // Constant-time slots ignore both, so timed ramps finish
  // RULE10: mute and ramp-down zero the effective target, stored target kept
  wire logic force_zero = ~is_ct & (ctrl.mute | ctrl.ramp_dn);
  wire logic [VAL_W-1:0] eff_t = force_zero ? '0 : (is_ct ? ct_target : cur.data);

  // Constant-time step code and count
  // Top time constant bit is the update request
  wire logic       ct_update = cur.tconst[3];
  wire logic [2:0] ct_code   = cur.tconst[2:0];
  wire logic [3:0] ct_shift  = CT_BASE_SHIFT + {1'b0, ct_code};

  // Coarse: every second code doubles the time constant
  // RULE22: exponential pace, whole shifts plus a three-quarter half-step
  wire logic [3:0] exp_sh = EXP_SHIFT_MIN + {1'b0, cur.tconst[3:1]};

  // One bit wider than stored values so sums never wrap
  logic signed [VAL_W:0]   s_x;
  logic signed [VAL_W:0]   t_x;
  logic signed [VAL_W:0]   diff;
  logic        [VAL_W:0]   abs_s;
  logic        [VAL_W:0]   abs_d;
  logic        [VAL_W:0]   exp_src;
  logic        [VAL_W:0]   exp_stp;
  logic        [VAL_W:0]   step;
  logic signed [VAL_W:0]   cand;
  logic signed [VAL_W:0]   ct_cand;
  logic                    overshoot;
  logic                    ct_over;
  logic        [VAL_W-1:0] next_slew;
  logic signed [VAL_W-1:0] new_ct_step;
  logic        [CNT_W-1:0] new_ct_left;

  // Per-entry ramp arithmetic, one entry per clock while scanning
  // One shared datapath serves all slots in turn
  always_comb begin
    s_x     = {cur_slew[VAL_W-1], cur_slew};
    t_x     = {eff_t[VAL_W-1], eff_t};
    diff    = t_x - s_x;
    abs_s   = s_x[VAL_W] ? (VAL_W+1)'(-s_x) : s_x;
    abs_d   = diff[VAL_W] ? (VAL_W+1)'(-diff) : diff;
    // RULE13: constant dB scales the current value; RULE14: RC scales the gap
    exp_src = (cur.curve == CURVE_CDB) ? abs_s : abs_d;
    exp_stp = exp_src >> exp_sh;
    if (cur.tconst[0]) begin
      exp_stp = exp_stp - (exp_stp >> 2);
    end
    // RULE12: linear uses a fixed step; RULE21: step chosen by time constant
    if (cur.curve == CURVE_LIN) begin
      step = {13'h0000, lin_step(cur.tconst)};
    end else begin
      step = exp_stp;
    end
    // Minimum of one LSB so a zero slew value can still climb
    // Without it a constant-dB ramp from zero stalls
    if (step == '0) begin
      step = (VAL_W+1)'(1);
    end
    cand      = diff[VAL_W] ? (s_x - $signed(step)) : (s_x + $signed(step));
    // RULE24: clamp at the target, never past it
    overshoot = diff[VAL_W] ? (cand <= t_x) : (cand >= t_x);
    // Count drops once per frame; zero ends the ramp
    // RULE15: constant time adds its precomputed step, snapping on the last one
    ct_cand   = s_x + {cur_ctst[VAL_W-1], cur_ctst};
    ct_over   = (diff == '0) | (diff[VAL_W] ? (ct_cand <= t_x) : (ct_cand >= t_x));
    if (is_ct) begin
      if (ct_update || cur_left == '0) begin
        next_slew = cur_slew;
      end else if (cur_left == CNT_W'(1) || ct_over) begin
        next_slew = eff_t;
      end else begin
        next_slew = ct_cand[VAL_W-1:0];
      end
    end else if (diff == '0 || overshoot) begin
      next_slew = eff_t;
    end else begin
      next_slew = cand[VAL_W-1:0];
    end
    // Arithmetic shift keeps the sign for falling ramps
    // RULE17: step recalculated from gap and count
    new_ct_step = VAL_W'(diff >>> ct_shift);
    // RULE18: top code keeps its printed count of 8196
    new_ct_left = (ct_code == CT_TOP_CODE) ? CT_TOP_COUNT : (CNT_W'(1) << ct_shift);
  end

  // Entries still off zero under ramp-down
  // Constant-time slots take no part in the ramp-down
  wire logic this_nz = ~is_ct & (cur_slew != '0);

  // Control bit update; set always beats the hardware clear
  // Self-clearing bits are set-only, so a rewrite with
  // them low can not abort a transfer or memory clear
  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl.mute    = wdata[BIT_MUTE];
      next_ctrl.clr_hi  = wdata[BIT_CLR_HI];
      next_ctrl.clr_n   = wdata[BIT_CLR_N];
      next_ctrl.ramp_dn = wdata[BIT_RAMP_DN];
    end
    // RULE23: request stays pending until the frame transfer takes it
    next_ctrl.load_go = (wr_ctrl & wdata[BIT_LOAD_GO]) | (ctrl.load_go & ~load_take);
    // RULE2: memory clear runs until its timer expires, then drops itself
    next_ctrl.memclr  = memclr_set | (ctrl.memclr & ~memclr_end);
  end

  // Control and staging registers
  // Staging words read back so software can verify them
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl       <= CTRL_RESET;
      stage_cfg  <= '0;
      stage_data <= '0;
      slew_sel   <= '0;
    end else begin
      ctrl <= next_ctrl;
      if (wr_cfg) begin
        stage_cfg <= wdata[13:0];
      end
      if (wr_data) begin
        stage_data <= wdata[VAL_W-1:0];
      end
      if (wr_sel) begin
        slew_sel <= wdata[IDX_W-1:0];
      end
    end
  end

  // A second set restarts the full wait
  // RULE2: memory clear timer, reloaded by every set
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mclr_cnt <= '0;
    end else if (memclr_set) begin
      mclr_cnt <= MCLR_W'(MEMCLR_CYCLES);
    end else if (ctrl.memclr) begin
      mclr_cnt <= mclr_cnt - MCLR_W'(1);
    end
  end

  // LRCLK synchroniser and edge history
  // Reset to the idle low level: no false tick on release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lr_s1 <= 1'b0;
      lr_s2 <= 1'b0;
      lr_s3 <= 1'b0;
    end else begin
      lr_s1 <= lrclk;
      lr_s2 <= lr_s1;
      lr_s3 <= lr_s2;
    end
  end

  // Sequencer: init walk after reset, then one full scan per frame
  // Ticks during init or scan are dropped, so a frame
  // must outlast the 64-cycle scan; audio rates do
  always_comb begin
    next_state = state;
    unique case (state)
      ST_INIT: if (idx == IDX_LAST) next_state = ST_IDLE;
      // RULE7: one scan per audio frame
      ST_IDLE: if (frame_tick) next_state = ST_SCAN;
      ST_SCAN: if (idx == IDX_LAST) next_state = ST_IDLE;
      // Illegal code falls into the init walk, which carries on from the current index
      default: next_state = ST_INIT;
    endcase
  end

  // Sequencer state, scan index and ramp-down completion
  // Scan result is judged at its last slot, then cleared
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= ST_INIT;
      idx       <= '0;
      nz_seen   <= 1'b0;
      ramp_done <= 1'b0;
    end else begin
      state <= next_state;
      if (state != ST_IDLE) begin
        idx <= idx + IDX_W'(1);
      end
      if (state == ST_SCAN) begin
        nz_seen <= (idx == IDX_LAST) ? 1'b0 : (nz_seen | this_nz);
      end
      // RULE4: done once a whole scan finds every entry except constant-time ones at zero
      if (!ctrl.ramp_dn) begin
        ramp_done <= 1'b0;
      end else if (state == ST_SCAN && idx == IDX_LAST) begin
        ramp_done <= ~(nz_seen | this_nz);
      end
    end
  end

  // Memory writes; init, transfer and scan never share a cycle
  // Transfers happen only while idle, so no scan ever
  // sees a half-written entry
  always_ff @(posedge clk) begin
    unique case (state)
      ST_INIT: begin
        // Step state cleared so no old ramp resumes
        // RULE20: default entry and unity slew
        tgt_mem[idx]  <= TGT_RESET;
        slew_mem[idx] <= UNITY;
        ct_step[idx]  <= '0;
        ct_left[idx]  <= '0;
      end
      ST_IDLE: begin
        // RULE6: a new target drives its paired slew on the following scans
        if (load_take) begin
          tgt_mem[stage_idx] <= staged;
        end
      end
      ST_SCAN: begin
        slew_mem[idx] <= next_slew;
        if (is_ct && ct_update) begin
          // RULE17: auto-clear of the update-step bit
          tgt_mem[idx].tconst[3] <= 1'b0;
          ct_step[idx]           <= new_ct_step;
          ct_left[idx]           <= new_ct_left;
        end else if (is_ct && cur_left != '0) begin
          ct_left[idx] <= cur_left - CNT_W'(1);
        end
      end
      default: begin
      end
    endcase
  end

  // Readback mux; unmapped offsets read zero
  // Done bit is read-only; writes to it are dropped
  wire logic [DATA_W-1:0] ctrl_rd = (DATA_W'(ctrl.load_go)   << BIT_LOAD_GO)
                                  | (DATA_W'(ctrl.mute)      << BIT_MUTE)
                                  | (DATA_W'(ctrl.clr_hi)    << BIT_CLR_HI)
                                  | (DATA_W'(ctrl.memclr)    << BIT_MEMCLR)
                                  | (DATA_W'(ctrl.clr_n)     << BIT_CLR_N)
                                  | (DATA_W'(ctrl.ramp_dn)   << BIT_RAMP_DN)
                                  | (DATA_W'(ramp_done)      << BIT_RAMP_DONE);
  wire logic [DATA_W-1:0] rd_mux  = (addr == OFF_CORE_CTRL) ? ctrl_rd :
                                    (addr == OFF_TGT_CFG)   ? DATA_W'(stage_cfg) :
                                    (addr == OFF_TGT_DATA)  ? DATA_W'(stage_data) :
                                    (addr == OFF_SLEW_IDX)  ? DATA_W'(slew_sel) :
                                    (addr == OFF_SLEW_VAL)  ? DATA_W'(slew_mem[slew_sel]) : '0;

  // Registered outputs; read data stands only in the cycle after the strobe
  // Every output is a flop, so no decode glitch leaves
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata        <= '0;
      dsp_slew     <= '0;
      core_clear   <= 1'b0;
      mem_clearing <= 1'b0;
    end else begin
      rdata        <= rd ? rd_mux : '0;
      dsp_slew     <= slew_mem[dsp_idx];
      // RULE1: core clear decode
      core_clear   <= ~ctrl.clr_n & ctrl.clr_hi;
      // Status copy, one cycle behind the register bit
      mem_clearing <= ctrl.memclr;
    end
  end

endmodule // tsr_ramp_engine

// file: sim/tsr_engine_checker.sv
// Port-level assertions for the target/slew ramp engine
`timescale 1ns/1ps
module tsr_engine_checker
  import tsr_pkg::*;
(
  input wire logic              clk,
  input wire logic              arst_n,
  input wire logic              lrclk,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [IDX_W-1:0]  dsp_idx,
  input wire logic [VAL_W-1:0]  dsp_slew,
  input wire logic              core_clear,
  input wire logic              mem_clearing
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic        ramp_sh;
  logic [2:0]  lr_sync;
  logic [7:0]  quiet;
  logic [12:0] clr_cnt;
  wire         ctrl_wr = wr && addr == OFF_CORE_CTRL;
  // Shadow ramp bit, cycles since a frame edge, length of a memory clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ramp_sh <= 1'b0;
      lr_sync <= 3'h0;
      quiet   <= 8'h00;
      clr_cnt <= 13'h0000;
    end else begin
      ramp_sh <= ctrl_wr ? wdata[BIT_RAMP_DN] : ramp_sh;
      lr_sync <= {lr_sync[1:0], lrclk};
      quiet   <= (lr_sync[2:1] == 2'h1) ? 8'h00 : quiet + {7'h00, quiet != 8'hff};
      clr_cnt <= mem_clearing ? clr_cnt + 13'h0001 : 13'h0000;
    end
  end
  property p_clear_on;
    ctrl_wr && !wdata[BIT_CLR_N] && wdata[BIT_CLR_HI] |-> ##2 core_clear;
  endproperty
  a_clear_on: assert property (p_clear_on) else $error("core clear not raised");
  property p_clear_off;
    ctrl_wr && (wdata[BIT_CLR_N] || !wdata[BIT_CLR_HI]) |-> ##2 !core_clear;
  endproperty
  a_clear_off: assert property (p_clear_off) else $error("core clear not dropped");
  property p_rdata_idle;
    !$past(rd) |-> rdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_unmapped;
    rd && addr == 8'h20 |=> rdata == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_memclr_start;
    ctrl_wr && wdata[BIT_MEMCLR] |-> ##2 mem_clearing;
  endproperty
  a_memclr_start: assert property (p_memclr_start) else $error("memory clear not started");
  property p_memclr_min;
    $fell(mem_clearing) |-> clr_cnt >= 13'd4000;
  endproperty
  a_memclr_min: assert property (p_memclr_min) else $error("memory clear too short");
  property p_memclr_end;
    clr_cnt <= 13'd4004;
  endproperty
  a_memclr_end: assert property (p_memclr_end) else $error("memory clear never ends");
  property p_done_low;
    rd && addr == OFF_CORE_CTRL && !ramp_sh |=> !rdata[BIT_RAMP_DONE];
  endproperty
  a_done_low: assert property (p_done_low) else $error("ramp done without ramp down");
  // Slew values only move in a frame scan, never between frames
  property p_slew_hold;
    quiet > 8'd80 && $stable(dsp_idx) |=> $stable(dsp_slew);
  endproperty
  a_slew_hold: assert property (p_slew_hold) else $error("slew moved between frames");
endmodule // tsr_engine_checker

bind tsr_ramp_engine tsr_engine_checker u_chk (.clk(clk), .arst_n(arst_n), .lrclk(lrclk), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .dsp_idx(dsp_idx), .dsp_slew(dsp_slew),
  .core_clear(core_clear), .mem_clearing(mem_clearing));

// file: sim/tsr_host_model.sv
// Host controller model driving the register port
`timescale 1ns/1ps
module tsr_host_model
  import tsr_pkg::*;
(
  input  wire logic              clk,
  output logic      [ADDR_W-1:0] addr,
  output logic      [DATA_W-1:0] wdata,
  output logic                   wr,
  output logic                   rd,
  input  wire logic [DATA_W-1:0] rdata
);
  logic [DATA_W-1:0] ctrl = '0; // Every control write carries all bits, so keep them
  initial begin
    addr  = '0;
    wdata = '0;
    wr    = 1'b0;
    rd    = 1'b0;
  end
  // Idle bus is scrambled so stale values never look valid
  task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
  endtask
  task automatic read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    addr <= ~a;
    #1 d = rdata;
  endtask
  task automatic set_ctrl(input logic [DATA_W-1:0] v);
    ctrl = v;
    write(OFF_CORE_CTRL, v);
  endtask
  task automatic load(input logic [IDX_W-1:0] slot, input logic [5:0] up, input logic [VAL_W-1:0] d);
    write(OFF_TGT_CFG, {18'h00000, slot, 2'h0, up});
    write(OFF_TGT_DATA, {4'h0, up[5:4] == 2'h3 ? {d[27:12], 12'h000} : d});
    write(OFF_CORE_CTRL, ctrl | (32'h1 << BIT_LOAD_GO));
  endtask
endmodule // tsr_host_model

// file: sim/tsr_ramp_engine_tb.sv
// Self-checking bench for the target/slew ramp engine
`timescale 1ns/1ps
module tsr_ramp_engine_tb
  import tsr_pkg::*;
;
  logic              clk;
  logic              arst_n;
  logic              lrclk;
  logic [IDX_W-1:0]  dsp_idx;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic [VAL_W-1:0]  dsp_slew;
  logic              wr;
  logic              rd;
  logic              core_clear;
  logic              mem_clearing;
  int                error_cnt = 0;
  int                checked   = 0;
  always #12.5 clk = ~clk;
  tsr_host_model u_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  tsr_ramp_engine u_dut (.clk(clk), .arst_n(arst_n), .lrclk(lrclk), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .dsp_idx(dsp_idx), .dsp_slew(dsp_slew), .core_clear(core_clear),
    .mem_clearing(mem_clearing));
  task automatic check_val(input logic [VAL_W-1:0] got, input logic [VAL_W-1:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  // Frames of 81 cycles leave the 64-slot scan time to finish
  task automatic frame(input int n);
    repeat (n) begin
      @(posedge clk);
      lrclk <= 1'b1;
      repeat (40) @(posedge clk);
      lrclk <= 1'b0;
      repeat (40) @(posedge clk);
    end
  endtask
  task automatic peek(input logic [IDX_W-1:0] slot, input logic [VAL_W-1:0] exp);
    @(posedge clk);
    dsp_idx <= slot;
    repeat (2) @(posedge clk);
    #1 check_val(dsp_slew, exp);
  endtask
  task automatic t_reset();
    logic [DATA_W-1:0] v;
    u_host.write(OFF_SLEW_IDX, 32'h0000003f);
    u_host.read(OFF_SLEW_VAL, v);
    check_val(v[27:0], 28'h0800000);
    u_host.read(8'h20, v);
    check_val(v[27:0], 28'h0000000);
    frame(1);
    peek(6'h00, 28'h0800000);
  endtask
  task automatic t_linear();
    logic [VAL_W-1:0] exp [4] = '{28'h07fe000, 28'h07fc000, 28'h07fb000, 28'h07fb000};
    u_host.load(6'h05, 6'h05, 28'h07fb000);
    for (int i = 0; i < 4; i++) begin
      frame(1);
      peek(6'h05, exp[i]);
    end
    peek(6'h04, 28'h0800000);
  endtask
  task automatic t_ct();
    u_host.load(6'h07, 6'h38, 28'h2000000);
    frame(1);
    peek(6'h07, 28'h0800000);
    frame(1);
    peek(6'h07, 28'h07f0000);
  endtask
  task automatic t_mute();
    u_host.set_ctrl(32'h00000208);
    frame(1);
    peek(6'h05, 28'h07f9000);
    peek(6'h07, 28'h07e0000);
    u_host.set_ctrl(32'h00000200);
    frame(1);
    peek(6'h05, 28'h07fb000);
  endtask
  task automatic t_exp();
    u_host.load(6'h0a, 6'h10, 28'h1000000);
    frame(1);
    peek(6'h0a, 28'h0840000);
    u_host.load(6'h09, 6'h20, 28'h1000000);
    frame(1);
    peek(6'h0a, 28'h0882000);
    peek(6'h09, 28'h0840000);
    frame(1);
    peek(6'h09, 28'h087e000);
    peek(6'h0a, 28'h08c6100);
  endtask
  task automatic t_clear();
    logic [DATA_W-1:0] cw [4] = '{32'h0, 32'h240, 32'h200, 32'h40};
    logic [DATA_W-1:0] v;
    int n;
    for (int i = 0; i < 4; i++) begin
      u_host.set_ctrl(cw[i]);
      repeat (2) @(posedge clk);
      #1 check_bit(core_clear, i == 3);
    end
    u_host.write(OFF_CORE_CTRL, u_host.ctrl | 32'h80);
    @(posedge clk);
    #1 check_bit(mem_clearing, 1'b1);
    n = 0;
    while (mem_clearing !== 1'b0 && n < 4100) begin
      @(posedge clk);
      n++;
    end
    check_bit(n > 3990 && n < 4100, 1'b1);
    if (n >= 4100) finish_test();
    u_host.read(OFF_CORE_CTRL, v);
    check_bit(v[BIT_MEMCLR], 1'b0);
    u_host.set_ctrl(32'h00000200);
  endtask
  task automatic t_ramp();
    logic [DATA_W-1:0] v;
    u_host.read(OFF_CORE_CTRL, v);
    check_bit(v[BIT_RAMP_DONE], 1'b0);
    u_host.set_ctrl(32'h00001200);
    frame(1);
    peek(6'h00, 28'h07fe000);
    u_host.read(OFF_CORE_CTRL, v);
    check_bit(v[BIT_RAMP_DONE], 1'b0);
    u_host.set_ctrl(32'h00000200);
    frame(1);
    peek(6'h00, 28'h0800000);
  endtask
  // Mid-run reset drops core clear at once and reloads defaults
  task automatic t_rst();
    u_host.set_ctrl(32'h00000040);
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check_bit(core_clear, 1'b0);
    @(posedge clk);
    arst_n <= 1'b1;
    repeat (70) @(posedge clk);
    u_host.set_ctrl(32'h00000200);
    peek(6'h05, 28'h0800000);
  endtask
  task automatic finish_test();
    $display("Mismatches %0d, comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Main sequence; init walk needs 64 cycles after reset
  initial begin
    clk     = 1'b0;
    arst_n  = 1'b0;
    lrclk   = 1'b0;
    dsp_idx = '0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (70) @(posedge clk);
    u_host.set_ctrl(32'h00000200);
    t_reset();
    t_linear();
    t_ct();
    t_mute();
    t_exp();
    t_clear();
    t_ramp();
    t_rst();
    finish_test();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("[FAIL] %0t run timed out", $time);
    finish_test();
  end
endmodule // tsr_ramp_engine_tb
